// [hdl/refresh_timer_mode_control.sv]
// Refresh controller mode registers, interval counter and refresh request sequencing.
//
// Functional notes
// - Mode control register loads 0x02 on reset and hardware standby.
// - Self-refresh during software standby when one memory type enabled.
// - Enable bits decode to timer, dynamic, pseudo-static; both set illegal.
// - Memory enabled forces three-state area 3 cycles; two-state setting bars waits.
// - Memory enabled locks mode bits 0,2,3,4 and timer registers, flag clear allowed.
// - Strobe bit picks dual write-enable or dual column strobe, dynamic only.
// - Column bit picks 8 or 9 bit columns, dynamic only.
// - Pin enable drives refresh strobe pin, otherwise pin is general I/O.
// - Mode control bit 1 is read-only and reads 1.
// - Refresh cycles inserted only with cycle enable and a memory type.
// - Flag and irq enable clear in any standby; clock select only hardware.
// - Flag sets on match; cleared by read-as-one then write zero.
// - Irq enable gates interrupt; forced to 0 while a memory is enabled.
// - Clock select 0 stops; 1..7 divide by 2,8,32,128,512,2048,4096.
// - Match gives refresh request in memory mode, interrupt in timer mode.
// - Control register bits 2..0 are read-only and read 1.
// - Counter increments on tick; match sets flag and clears counter.
// - Counter clears on reset and entry to either standby.
// - Constant loads 0xFF on reset or hardware standby, kept in software standby.
// - First request after reset or standby only enters pending state.
// - Requests arriving during a refresh cycle are discarded.
`include "refresh_timer_regs.svh"

module refresh_timer_mode_control (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [`RT_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic hw_standby_i,
  input wire logic sw_standby_i,
  input wire logic area3_three_state_access_i,
  input wire logic refresh_done_i,
  output refresh_timer_pkg::area3_ctrl_t area3_ctrl_o,
  output logic refresh_request_o,
  output logic refresh_cycle_o,
  output logic compare_interrupt_o
);
  import refresh_timer_pkg::*;

  // ==========================================================
  // Pin synchronisers and standby entry detection.

  // Synchroniser stages and the delayed software standby level.
  logic [1:0] hw_sync_q;
  logic [1:0] sw_sync_q;
  logic sw_seen_q;
  logic hw_stby;
  logic sw_stby;
  logic sw_entry;

  // Standby levels come from pins, so two flops precede any use.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hw_sync_q <= 2'b00;
      sw_sync_q <= 2'b00;
      sw_seen_q <= 1'b0;
    end else begin
      hw_sync_q <= {hw_sync_q[0], hw_standby_i};
      sw_sync_q <= {sw_sync_q[0], sw_standby_i};
      sw_seen_q <= sw_sync_q[1];
    end
  end

  // Hardware standby acts as a held reset; software standby acts on entry.
  // Limitation: a standby pulse shorter than one clock may be missed.
  assign hw_stby = hw_sync_q[1];
  assign sw_stby = sw_sync_q[1];
  assign sw_entry = sw_stby & ~sw_seen_q;

  // ==========================================================
  // Registers and mode decode.

  // Register state; the field layout follows the header constants.
  logic [7:0] mode_q;
  logic flag_q;
  logic ie_q;
  logic [2:0] cks_q;
  logic [7:0] cnt_q;
  logic [7:0] cor_q;
  logic armed_q;
  logic mem_on;
  logic dram_only;
  mem_mode_t mode;

  // Decode of the two enable bits, used by several processes.
  function automatic mem_mode_t decode_mode(input logic [7:0] m);
    unique case ({m[`RT_MC_PSE], m[`RT_MC_DRE]})
      2'b00: decode_mode = MODE_TIMER;
      2'b01: decode_mode = MODE_DRAM;
      2'b10: decode_mode = MODE_PSRAM;
      2'b11: decode_mode = MODE_ILLEGAL;
    endcase
  endfunction : decode_mode

  assign mode = decode_mode(mode_q);
  // Illegal setting is left unhandled beyond counting as memory enabled.
  assign mem_on = (mode != MODE_TIMER);
  assign dram_only = (mode == MODE_DRAM);

  // ==========================================================
  // Avalon-MM handshake: every access sees exactly one wait cycle.

  // Handshake state and the one-cycle transfer strobes.
  logic ack_q;
  logic req;
  logic wr_go;
  logic rd_go;

  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_go = avs_write_i & ack_q & avs_byteenable_i[0];
  assign rd_go = avs_read_i & ack_q;

  // The ack flop gives registered read data a cycle to settle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read data is captured in the wait cycle and held through the answer.
  // An unmapped address reads as zero.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_q) begin
      unique case (avs_address_i)
        `RT_OFS_MODE: avs_readdata_o <= {24'h00_0000, mode_q | 8'h02};
        `RT_OFS_CSR: avs_readdata_o <= {24'h00_0000, flag_q, ie_q, cks_q,
                                        `RT_CS_RSV_BITS};
        `RT_OFS_CNT: avs_readdata_o <= {24'h00_0000, cnt_q};
        `RT_OFS_COR: avs_readdata_o <= {24'h00_0000, cor_q};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Per-register write strobes, qualified by the lock where it applies.
  logic wr_mode;
  logic wr_csr;
  logic wr_cnt;
  logic wr_cor;
  logic [7:0] wd;

  assign wd = avs_writedata_i[7:0];
  assign wr_mode = wr_go & (avs_address_i == `RT_OFS_MODE);
  assign wr_csr = wr_go & (avs_address_i == `RT_OFS_CSR);
  // Timer registers are locked while a memory type is enabled.
  assign wr_cnt = wr_go & (avs_address_i == `RT_OFS_CNT) & ~mem_on;
  assign wr_cor = wr_go & (avs_address_i == `RT_OFS_COR) & ~mem_on;

  // ==========================================================
  // Mode control register.

  // Bits 7, 6, 5 stay writable so software can leave a memory mode.
  always_ff @(posedge clk_i) begin
    if (srst_i | hw_stby) begin
      mode_q <= `RT_MC_RESET;
    end else if (wr_mode) begin
      if (mem_on) begin
        mode_q <= (mode_q & `RT_MC_LOCK_MASK) | (wd & ~`RT_MC_LOCK_MASK) | 8'h02;
      end else begin
        mode_q <= wd | 8'h02;
      end
    end
  end

  // ==========================================================
  // Timer control and status register.

  // Compare match on a prescaler tick, shared by flag, counter and sequencer.
  logic match_tick;

  // Clock select survives software standby, the enable does not.
  always_ff @(posedge clk_i) begin
    if (srst_i | hw_stby) begin
      cks_q <= 3'h0;
    end else if (wr_csr & ~mem_on) begin
      cks_q <= wd[`RT_CS_CKS_HI:`RT_CS_CKS_LO];
    end
  end

  // The irq enable cannot be set while a memory mode owns the timer.
  always_ff @(posedge clk_i) begin
    if (srst_i | hw_stby | sw_entry) begin
      ie_q <= 1'b0;
    end else if (mem_on) begin
      ie_q <= 1'b0;
    end else if (wr_csr) begin
      ie_q <= wd[`RT_CS_IE];
    end
  end

  // A read that sees the flag set arms the clear; any csr write disarms.
  always_ff @(posedge clk_i) begin
    if (srst_i | hw_stby | sw_entry) begin
      armed_q <= 1'b0;
    end else if (rd_go & (avs_address_i == `RT_OFS_CSR) & flag_q) begin
      armed_q <= 1'b1;
    end else if (wr_csr) begin
      armed_q <= 1'b0;
    end
  end

  // A match in the clearing cycle wins, so no event is lost.
  // Software that loses a clear to a match must read the flag again first.
  always_ff @(posedge clk_i) begin
    if (srst_i | hw_stby | sw_entry) begin
      flag_q <= 1'b0;
    end else if (match_tick) begin
      flag_q <= 1'b1;
    end else if (wr_csr & armed_q & ~wd[`RT_CS_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  // ==========================================================
  // Prescaler and counter.

  // Prescaler state and the selected tick.
  logic [`RT_PRE_W-1:0] pre_q;
  logic tick;

  // One free-running prescaler feeds every divide ratio.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + {{(`RT_PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // A tick fires when the low bits of the prescaler reach all ones.
  function automatic logic sel_tick(input logic [2:0] s,
                                    input logic [`RT_PRE_W-1:0] p);
    unique case (s)
      3'h0: sel_tick = 1'b0;
      3'h1: sel_tick = &p[0:0];
      3'h2: sel_tick = &p[2:0];
      3'h3: sel_tick = &p[4:0];
      3'h4: sel_tick = &p[6:0];
      3'h5: sel_tick = &p[8:0];
      3'h6: sel_tick = &p[10:0];
      3'h7: sel_tick = &p[11:0];
    endcase
  endfunction : sel_tick

  assign tick = sel_tick(cks_q, pre_q);
  // Standby entry wins over a match in the same cycle, as it clears the counter.
  assign match_tick = tick & (cnt_q == cor_q) & ~hw_stby & ~sw_entry;

  // A software write to the counter takes priority over counting.
  always_ff @(posedge clk_i) begin
    if (srst_i | hw_stby | sw_entry) begin
      cnt_q <= `RT_CNT_RESET;
    end else if (wr_cnt) begin
      cnt_q <= wd;
    end else if (match_tick) begin
      cnt_q <= `RT_CNT_RESET;
    end else if (tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // The constant survives software standby so the refresh interval is kept.
  always_ff @(posedge clk_i) begin
    if (srst_i | hw_stby) begin
      cor_q <= `RT_COR_RESET;
    end else if (wr_cor) begin
      cor_q <= wd;
    end
  end

  // ==========================================================
  // Refresh request sequencing.

  // Sequencer state and the request that drives it.
  refresh_state_t rf_q;
  logic rf_req;

  assign rf_req = match_tick & mem_on & mode_q[`RT_MC_CYC];

  // The first request only arms pending; later ones start a cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i | hw_stby | sw_stby) begin
      rf_q <= RF_IDLE;
    end else begin
      unique case (rf_q)
        RF_IDLE: if (rf_req) rf_q <= RF_PENDING;
        RF_PENDING: if (rf_req) rf_q <= RF_BUSY;
        RF_BUSY: if (refresh_done_i) rf_q <= RF_PENDING;
        default: rf_q <= RF_IDLE; // The unused code falls back to idle.
      endcase
    end
  end

  // ==========================================================
  // Registered outputs.

  // Request, cycle and interrupt outputs are registered so they never glitch.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      refresh_request_o <= 1'b0;
      refresh_cycle_o <= 1'b0;
      compare_interrupt_o <= 1'b0;
    end else begin
      refresh_request_o <= rf_req;
      refresh_cycle_o <= (rf_q == RF_BUSY);
      compare_interrupt_o <= flag_q & ie_q & ~mem_on;
    end
  end

  // Bus-cycle controls for area 3, one flop stage after the registers.
  // Self-refresh needs exactly one memory type; the illegal code never qualifies.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      area3_ctrl_o <= '0;
    end else begin
      area3_ctrl_o.mode <= mode;
      area3_ctrl_o.cas_mode <= dram_only & mode_q[`RT_MC_STROBE];
      area3_ctrl_o.col9 <= dram_only & mode_q[`RT_MC_COL];
      area3_ctrl_o.pin_enable <= mode_q[`RT_MC_PIN];
      area3_ctrl_o.cycle_enable <= mem_on & mode_q[`RT_MC_CYC];
      area3_ctrl_o.three_state <= mem_on | area3_three_state_access_i;
      area3_ctrl_o.wait_allowed <= area3_three_state_access_i;
      area3_ctrl_o.self_refresh <= mode_q[`RT_MC_SELF] & sw_stby &
                                   (mode inside {MODE_DRAM, MODE_PSRAM});
    end
  end

endmodule : refresh_timer_mode_control

// [hdl/refresh_timer_regs.svh]
// Register offsets, field positions and reset values of the refresh timer.
`ifndef REFRESH_TIMER_REGS_SVH
`define REFRESH_TIMER_REGS_SVH

// ==========================================================
// Register byte addresses on the Avalon-MM port.
`define RT_ADDR_W 4
`define RT_OFS_MODE 4'h0
`define RT_OFS_CSR 4'h4
`define RT_OFS_CNT 4'h8
`define RT_OFS_COR 4'hC

// ==========================================================
// Mode control fields.
`define RT_MC_SELF 7
`define RT_MC_PSE 6
`define RT_MC_DRE 5
`define RT_MC_STROBE 4
`define RT_MC_COL 3
`define RT_MC_PIN 2
`define RT_MC_RSV 1
`define RT_MC_CYC 0
`define RT_MC_RESET 8'h02
`define RT_MC_LOCK_MASK 8'h1D

// ==========================================================
// Timer control and status fields.
`define RT_CS_FLAG 7
`define RT_CS_IE 6
`define RT_CS_CKS_HI 5
`define RT_CS_CKS_LO 3
`define RT_CS_RSV_BITS 3'h7

// ==========================================================
// Counter and constant reset values, prescaler width.
`define RT_CNT_RESET 8'h00
`define RT_COR_RESET 8'hFF
`define RT_PRE_W 12

`endif

// [hdl/refresh_timer_pkg.sv]
// Types shared by the refresh timer and its users.
package refresh_timer_pkg;

  // Operating mode decoded from the two memory-enable bits.
  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_DRAM,
    MODE_PSRAM,
    MODE_ILLEGAL
  } mem_mode_t;

  // Refresh sequencing state.
  typedef enum logic [1:0] {
    RF_IDLE,
    RF_PENDING,
    RF_BUSY
  } refresh_state_t;

  // Controls handed to the area 3 bus-cycle logic.
  typedef struct packed {
    mem_mode_t mode;
    logic cas_mode;
    logic col9;
    logic pin_enable;
    logic cycle_enable;
    logic three_state;
    logic wait_allowed;
    logic self_refresh;
  } area3_ctrl_t;

endpackage : refresh_timer_pkg

// [testbench/refresh_timer_sva.sv]
// Port-level property checker for the refresh timer.
`include "refresh_timer_regs.svh"
// ==========================================================
// Checker
module refresh_timer_sva (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [`RT_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic hw_standby_i,
  input wire logic sw_standby_i,
  input wire logic area3_three_state_access_i,
  input wire logic refresh_done_i,
  input wire refresh_timer_pkg::area3_ctrl_t area3_ctrl_o,
  input wire logic refresh_request_o,
  input wire logic refresh_cycle_o,
  input wire logic compare_interrupt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import refresh_timer_pkg::*;
  // All checks share the one clock and its synchronous reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // A fresh request always sees exactly one wait cycle.
  AST_WAIT_FIRST: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("waitrequest low on a fresh request");
  AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("more than one wait cycle");
  AST_MODE_BIT1: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i == `RT_OFS_MODE |-> avs_readdata_o[1])
    else $error("mode bit 1 read as 0");
  AST_CSR_LOW: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i == `RT_OFS_CSR |-> avs_readdata_o[2:0] == 3'h7)
    else $error("control low bits not all ones");
  AST_IRQ_TIMER: assert property (compare_interrupt_o |-> area3_ctrl_o.mode == MODE_TIMER)
    else $error("interrupt outside timer mode");
  // Leaving a memory mode may race the last request by one cycle.
  AST_REQ_MEM: assert property (refresh_request_o |-> area3_ctrl_o.mode != MODE_TIMER
    || $past(area3_ctrl_o.mode) != MODE_TIMER)
    else $error("refresh request in timer mode");
  AST_REQ_PULSE: assert property (refresh_request_o |=> !refresh_request_o)
    else $error("refresh request wider than one cycle");
  AST_THREE: assert property (area3_ctrl_o.mode != MODE_TIMER |-> area3_ctrl_o.three_state)
    else $error("memory mode without three-state cycles");
  AST_CYCLE_CAUSE: assert property ($rose(refresh_cycle_o) |-> $past(refresh_request_o))
    else $error("refresh cycle without a request");
  // The cycle output lags the sequencer by one clock, so done shows two edges later.
  AST_CYCLE_HOLD: assert property (refresh_cycle_o && !refresh_done_i && !$past(refresh_done_i)
    && !sw_standby_i && !hw_standby_i |=> refresh_cycle_o)
    else $error("refresh cycle ended early");
  AST_CYCLE_DONE: assert property (refresh_cycle_o && refresh_done_i |-> ##2 !refresh_cycle_o)
    else $error("refresh cycle kept after done");
  AST_RESET_OUT: assert property ($fell(srst_i) |-> !refresh_cycle_o && !compare_interrupt_o
    && area3_ctrl_o.mode == MODE_TIMER)
    else $error("outputs not idle after reset");
endmodule : refresh_timer_sva

bind refresh_timer_mode_control refresh_timer_sva u_sva (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .hw_standby_i(hw_standby_i),
  .sw_standby_i(sw_standby_i),
  .area3_three_state_access_i(area3_three_state_access_i),
  .refresh_done_i(refresh_done_i),
  .area3_ctrl_o(area3_ctrl_o),
  .refresh_request_o(refresh_request_o),
  .refresh_cycle_o(refresh_cycle_o),
  .compare_interrupt_o(compare_interrupt_o)
);

// [testbench/tb.sv]
// Self-checking bench for the refresh timer.
`include "refresh_timer_regs.svh"
// ==========================================================
// Bench
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import refresh_timer_pkg::*;
  logic clk_i, srst_i, avs_read_i, avs_write_i, hw_standby_i, sw_standby_i;
  logic area3_three_state_access_i, refresh_done_i, avs_waitrequest_o;
  logic refresh_request_o, refresh_cycle_o, compare_interrupt_o;
  logic [`RT_ADDR_W-1:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, r;
  logic [3:0] avs_byteenable_i;
  area3_ctrl_t area3_ctrl_o;
  logic [7:0] c, x;
  int n_mismatch, checked, n;

  refresh_timer_mode_control DUT (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .hw_standby_i(hw_standby_i),
    .sw_standby_i(sw_standby_i),
    .area3_three_state_access_i(area3_three_state_access_i),
    .refresh_done_i(refresh_done_i),
    .area3_ctrl_o(area3_ctrl_o),
    .refresh_request_o(refresh_request_o),
    .refresh_cycle_o(refresh_cycle_o),
    .compare_interrupt_o(compare_interrupt_o)
  );

  // Free-running 20 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One bus transfer; waitrequest and read data are taken at the same rising edge.
  // Only the watchdog ends a wait that never sees waitrequest low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(r, {24'h00_0000, e});
  endtask : rd

  task automatic pchk(ref logic s, input logic e);
    @(negedge clk_i);
    chk(s, e);
    @(posedge clk_i);
  endtask : pchk

  // Counts cycles up to the next refresh request pulse.
  task automatic wq();
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (refresh_request_o !== 1'b1 && n < 9000);
    @(posedge clk_i);
  endtask : wq

  function automatic int dv(input int k);
    return (k == 7) ? 4096 : (1 << (2 * k - 1));
  endfunction : dv

  function automatic logic [7:0] ce(input logic f, input logic ie, input logic [2:0] k);
    return {f, ie, k, 3'h7};
  endfunction : ce

  task automatic end_of_test();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Watchdog sized well beyond the slowest divide sweep.
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    {avs_read_i, avs_write_i, hw_standby_i, sw_standby_i, refresh_done_i} = 5'h00;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'hF;
    void'($urandom(87134));
    area3_three_state_access_i = 1'($urandom);
    srst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(`RT_OFS_MODE, 8'h02);
    rd(`RT_OFS_CSR, 8'h07);
    rd(`RT_OFS_CNT, 8'h00);
    avs_byteenable_i <= 4'hE;
    wr(`RT_OFS_COR, 8'h55);
    avs_byteenable_i <= 4'hF;
    rd(`RT_OFS_COR, 8'hFF);
    rd(4'h2, 8'h00);
    wr(`RT_OFS_MODE, 8'h00);
    rd(`RT_OFS_MODE, 8'h02);
    $display("test reset done");
    c = 8'($urandom_range(1, 5));
    wr(`RT_OFS_COR, c);
    wr(`RT_OFS_CNT, 8'h00);
    wr(`RT_OFS_CSR, ce(1'b0, 1'b1, 3'h1));
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (compare_interrupt_o !== 1'b1 && n < 100);
    chk(32'(n >= 2 * c + 2 && n <= 2 * c + 3), 32'h0000_0001);
    @(posedge clk_i);
    wr(`RT_OFS_CSR, 8'hC0);
    rd(`RT_OFS_CSR, ce(1'b1, 1'b1, 3'h0));
    wr(`RT_OFS_CSR, 8'h40);
    rd(`RT_OFS_CSR, ce(1'b0, 1'b1, 3'h0));
    pchk(compare_interrupt_o, 1'b0);
    $display("test timer done");
    wr(`RT_OFS_MODE, 8'h1D);
    wr(`RT_OFS_MODE, 8'h3D);
    @(negedge clk_i);
    chk(area3_ctrl_o, {MODE_DRAM, 5'h1F, area3_three_state_access_i, 1'b0});
    @(posedge clk_i);
    bus(1'b0, `RT_OFS_CNT, 8'h00);
    x = r[7:0];
    wr(`RT_OFS_CNT, ~x);
    rd(`RT_OFS_CNT, x);
    wr(`RT_OFS_COR, c ^ 8'($urandom_range(1, 255)));
    rd(`RT_OFS_COR, c);
    wr(`RT_OFS_CSR, 8'h78);
    rd(`RT_OFS_CSR, 8'h07);
    wr(`RT_OFS_MODE, 8'h21);
    rd(`RT_OFS_MODE, 8'h3F);
    wr(`RT_OFS_MODE, 8'h41);
    @(negedge clk_i);
    chk(area3_ctrl_o.mode, MODE_PSRAM);
    @(posedge clk_i);
    wr(`RT_OFS_MODE, 8'h00);
    $display("test lock done");
    wr(`RT_OFS_COR, 8'h00);
    for (int k = 1; k < 8; k++) begin
      wr(`RT_OFS_MODE, 8'h00);
      wr(`RT_OFS_CNT, 8'h00);
      wr(`RT_OFS_CSR, ce(1'b0, 1'b0, 3'(k)));
      wr(`RT_OFS_MODE, 8'h21);
      wq();
      wq();
      chk(n, dv(k));
    end
    $display("test divide done");
    pchk(refresh_cycle_o, 1'b1);
    refresh_done_i <= 1'b1;
    @(posedge clk_i);
    refresh_done_i <= 1'b0;
    @(posedge clk_i);
    pchk(refresh_cycle_o, 1'b0);
    wq();
    @(posedge clk_i);
    pchk(refresh_cycle_o, 1'b1);
    $display("test refresh done");
    wr(`RT_OFS_MODE, 8'hA1);
    sw_standby_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk(area3_ctrl_o.self_refresh, 1'b1);
    @(posedge clk_i);
    sw_standby_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk(area3_ctrl_o.self_refresh, 1'b0);
    @(posedge clk_i);
    rd(`RT_OFS_CSR, ce(1'b0, 1'b0, 3'h7));
    hw_standby_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    hw_standby_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(`RT_OFS_MODE, 8'h02);
    rd(`RT_OFS_CSR, 8'h07);
    rd(`RT_OFS_CNT, 8'h00);
    rd(`RT_OFS_COR, 8'hFF);
    $display("test standby done");
    end_of_test();
  end
endmodule : tb
